// file: pcr_defs.svh
// Offsets, reset values, limits and field positions of the calibration register bank.
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH
// ==========================================================================
// Register indices (byte address is four times the index).
`define PCR_IDX_PRES_H    6'h0B
`define PCR_IDX_PRES_L    6'h0C
`define PCR_IDX_BASE_H    6'h0D
`define PCR_IDX_BASE_L    6'h0E
`define PCR_IDX_SCRATCH   6'h0F
`define PCR_IDX_STATUS    6'h10
`define PCR_IDX_MASK      6'h11
// ==========================================================================
// Reset values.
`define PCR_RST_PRES_H    8'h03
`define PCR_RST_PRES_L    8'hF7
`define PCR_RST_BASE_H    8'h01
`define PCR_RST_BASE_L    8'h90
`define PCR_RST_SCRATCH   8'h00
`define PCR_RST_FLAGS     1'h0
// ==========================================================================
// Permitted ranges: 750 and 1150 hPa, 350 and 1500 ppm.
`define PCR_PRES_MIN      16'h02EE
`define PCR_PRES_MAX      16'h047E
`define PCR_BASE_MIN      16'sh015E
`define PCR_BASE_MAX      16'sh05DC
// ==========================================================================
// Field positions.
`define PCR_STS_COMM_ERR  0
`define PCR_BYTE_MSB      7
`define PCR_ADR_IDX_LSB   2
`endif

// file: pcr_pkg.sv
// Types shared by the calibration register bank.
package pcr_pkg;
    // ======================================================================
    // Data types.
    typedef logic [7:0]         pcr_byte_t;
    typedef logic [15:0]        pcr_word_t;
    typedef logic signed [15:0] pcr_sword_t;
    typedef logic [5:0]         pcr_idx_t;
endpackage : pcr_pkg

// file: pcr_regs.sv
// Pressure compensation, baseline reference and scratch registers on a Wishbone slave.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "pcr_defs.svh"

module pcr_regs (
    // System.
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Wishbone classic slave.
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output      logic [31:0]       wb_dat_o,
    output      logic              wb_ack_o,
    // Values used by the measurement logic.
    output      pcr_pkg::pcr_word_t  pres_shadow,
    output      logic                pres_comp_active,
    output      pcr_pkg::pcr_sword_t baseline_ref,
    // Interrupt.
    output      logic              irq
);

    // ======================================================================
    // Bus decode.
    logic                ack_ff;
    logic [31:0]         rdat_ff;
    logic                acc;
    logic                wr;
    pcr_pkg::pcr_idx_t   idx;
    pcr_pkg::pcr_byte_t  wbyte;

    assign acc   = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr    = acc & wb_we_i & wb_sel_i[0];
    assign idx   = wb_adr_i[7:`PCR_ADR_IDX_LSB];
    assign wbyte = wb_dat_i[`PCR_BYTE_MSB:0];

    // ======================================================================
    // Register state.
    pcr_pkg::pcr_byte_t  pres_h_ff;
    pcr_pkg::pcr_byte_t  pres_l_ff;
    pcr_pkg::pcr_byte_t  base_h_ff;
    pcr_pkg::pcr_byte_t  base_l_ff;
    pcr_pkg::pcr_byte_t  scratch_ff;
    pcr_pkg::pcr_word_t  shadow_ff;
    logic                active_ff;
    logic                err_ff;
    logic                mask_ff;
    logic                irq_ff;

    // ======================================================================
    // Range checks on the value as it would be written.
    pcr_pkg::pcr_word_t  pres_new;
    pcr_pkg::pcr_word_t  pres_clamp;
    pcr_pkg::pcr_sword_t base_new;
    pcr_pkg::pcr_sword_t base_clamp;
    logic                pres_bad;
    logic                base_bad;
    logic                pres_wr_l;
    logic                base_wr_l;
    logic                nxt_err;

    assign pres_new = {pres_h_ff, wbyte};
    assign base_new = $signed({base_h_ff, wbyte});

    always_comb begin
        pres_clamp = pres_new;
        pres_bad   = 1'b0;
        if (pres_new < `PCR_PRES_MIN) begin
            pres_clamp = `PCR_PRES_MIN;
            pres_bad   = 1'b1;
        end
        else if (pres_new > `PCR_PRES_MAX) begin
            pres_clamp = `PCR_PRES_MAX;
            pres_bad   = 1'b1;
        end
    end

    always_comb begin
        base_clamp = base_new;
        base_bad   = 1'b0;
        if (base_new < `PCR_BASE_MIN) begin
            base_clamp = `PCR_BASE_MIN;
            base_bad   = 1'b1;
        end
        else if (base_new > `PCR_BASE_MAX) begin
            base_clamp = `PCR_BASE_MAX;
            base_bad   = 1'b1;
        end
    end

    assign pres_wr_l = wr && idx == `PCR_IDX_PRES_L;
    assign base_wr_l = wr && idx == `PCR_IDX_BASE_L;

    // ======================================================================
    // Pressure bytes and shadow.
    // Checking only on the low byte lets the host pass through an out-of-range
    // intermediate value while the high byte alone is being changed.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pres_h_ff <= `PCR_RST_PRES_H;
            pres_l_ff <= `PCR_RST_PRES_L;
            shadow_ff <= {`PCR_RST_PRES_H, `PCR_RST_PRES_L};
        end else if (pres_wr_l) begin
            pres_h_ff <= pres_clamp[15:8];
            pres_l_ff <= pres_clamp[7:0];
            shadow_ff <= pres_clamp;
        end else if (wr && idx == `PCR_IDX_PRES_H) begin
            pres_h_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            active_ff <= 1'b0;
        end else if (pres_wr_l) begin
            active_ff <= 1'b1;
        end
    end

    // ======================================================================
    // Baseline reference bytes.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            base_h_ff <= `PCR_RST_BASE_H;
            base_l_ff <= `PCR_RST_BASE_L;
        end else if (base_wr_l) begin
            base_h_ff <= base_clamp[15:8];
            base_l_ff <= base_clamp[7:0];
        end else if (wr && idx == `PCR_IDX_BASE_H) begin
            base_h_ff <= wbyte;
        end
    end

    // ======================================================================
    // Scratch byte.
    // Storage only, read back.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scratch_ff <= `PCR_RST_SCRATCH;
        end else if (wr && idx == `PCR_IDX_SCRATCH) begin
            scratch_ff <= wbyte;
        end
    end

    // ======================================================================
    // Status, mask and interrupt.
    always_comb begin
        nxt_err = err_ff;
        if (wr && idx == `PCR_IDX_STATUS && wbyte[`PCR_STS_COMM_ERR]) begin
            nxt_err = 1'b0;
        end
        // Set error on clamp, set wins.
        if ((pres_wr_l && pres_bad) || (base_wr_l && base_bad)) begin
            nxt_err = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            err_ff <= `PCR_RST_FLAGS;
        end else begin
            err_ff <= nxt_err;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_ff <= `PCR_RST_FLAGS;
        end else if (wr && idx == `PCR_IDX_MASK) begin
            mask_ff <= wbyte[`PCR_STS_COMM_ERR];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= err_ff & mask_ff;
        end
    end

    // ======================================================================
    // Bus answer: one wait state, unmapped reads give zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= acc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdat_ff <= 32'h0;
        end else if (acc) begin
            rdat_ff <= 32'h0;
            unique case (idx)
                `PCR_IDX_PRES_H:  rdat_ff[7:0] <= pres_h_ff;
                `PCR_IDX_PRES_L:  rdat_ff[7:0] <= pres_l_ff;
                `PCR_IDX_BASE_H:  rdat_ff[7:0] <= base_h_ff;
                `PCR_IDX_BASE_L:  rdat_ff[7:0] <= base_l_ff;
                `PCR_IDX_SCRATCH: rdat_ff[7:0] <= scratch_ff;
                `PCR_IDX_STATUS:  rdat_ff[`PCR_STS_COMM_ERR] <= err_ff;
                `PCR_IDX_MASK:    rdat_ff[`PCR_STS_COMM_ERR] <= mask_ff;
                default:          rdat_ff <= 32'h0;
            endcase
        end
    end

    assign wb_dat_o           = rdat_ff;
    assign wb_ack_o           = ack_ff;
    assign pres_shadow      = shadow_ff;
    assign pres_comp_active = active_ff;
    assign baseline_ref     = $signed({base_h_ff, base_l_ff});
    assign irq              = irq_ff;

    // ======================================================================
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_shadow_load;
        pres_wr_l |=> shadow_ff == {pres_h_ff, pres_l_ff};
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");

    property p_shadow_hold;
        !pres_wr_l |=> $stable(shadow_ff);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("shadow moved");

    property p_pres_min;
        pres_wr_l && pres_new < `PCR_PRES_MIN |=> shadow_ff == `PCR_PRES_MIN && err_ff;
    endproperty
    a_pres_min: assert property (p_pres_min) else $error("pressure low clamp");

    property p_pres_max;
        pres_wr_l && pres_new > `PCR_PRES_MAX |=> shadow_ff == `PCR_PRES_MAX && err_ff;
    endproperty
    a_pres_max: assert property (p_pres_max) else $error("pressure high clamp");

    property p_base_min;
        base_wr_l && base_new < `PCR_BASE_MIN |=> baseline_ref == `PCR_BASE_MIN && err_ff;
    endproperty
    a_base_min: assert property (p_base_min) else $error("reference low clamp");

    property p_base_max;
        base_wr_l && base_new > `PCR_BASE_MAX |=> baseline_ref == `PCR_BASE_MAX && err_ff;
    endproperty
    a_base_max: assert property (p_base_max) else $error("reference high clamp");

    property p_active;
        !active_ff |-> shadow_ff == {`PCR_RST_PRES_H, `PCR_RST_PRES_L};
    endproperty
    a_active: assert property (p_active) else $error("shadow changed while inactive");

    property p_err_rise;
        $rose(err_ff) |-> $past(pres_wr_l && pres_bad || base_wr_l && base_bad);
    endproperty
    a_err_rise: assert property (p_err_rise) else $error("error without cause");

    property p_irq;
        err_ff && mask_ff |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_ack;
        acc |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");

    property p_scratch;
        wr && idx == `PCR_IDX_SCRATCH |=> scratch_ff == $past(wbyte);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch not stored");

endmodule : pcr_regs

// file: pcr_host.sv
// Host-side Wishbone classic master model for the calibration register bank.
`timescale 1ns/1ps

module pcr_host (
    // System.
    input  wire logic        clk_sys,
    // Wishbone classic master.
    output      logic        wb_cyc_o,
    output      logic        wb_stb_o,
    output      logic        wb_we_o,
    output      logic [7:0]  wb_adr_o,
    output      logic [3:0]  wb_sel_o,
    output      logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end

    // ======================================================================
    // One access, held until ack is sampled or 16 clocks pass; released address and data lines show the inverse.
    task automatic acc(input logic we, input logic [7:0] adr, input logic [31:0] d,
                       input logic [3:0] sel, output logic ok);
        int n;
        @(posedge clk_sys);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 16);
        ok = (wb_ack_i === 1'b1);
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o  <= 1'b0;
        wb_adr_o <= ~adr;
        wb_dat_o <= ~d;
    endtask : acc
endmodule : pcr_host

// file: pcr_regs_bench.sv
// Self-checking bench for the calibration register bank.
`timescale 1ns/1ps
`include "pcr_defs.svh"

module pcr_regs_bench;
    localparam logic [7:0] A_PH = {`PCR_IDX_PRES_H, 2'b00};
    localparam logic [7:0] A_BH = {`PCR_IDX_BASE_H, 2'b00};
    localparam logic [7:0] A_SC = {`PCR_IDX_SCRATCH, 2'b00};
    localparam logic [7:0] A_ST = {`PCR_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_MK = {`PCR_IDX_MASK, 2'b00};
    logic                clk_sys = 1'b0;
    logic                rst_n = 1'b0;
    logic                cyc, stb, we, ack, ok, irq, act;
    logic [7:0]          adr, s;
    logic [3:0]          sel;
    logic [31:0]         dat_w, dat_r;
    pcr_pkg::pcr_word_t  shadow;
    pcr_pkg::pcr_sword_t bref;
    logic [31:0]         exp_q[$];
    logic [15:0]         t_in[12], t_ex[12];
    logic                t_rf[12], t_er[12];
    int                  n_fail = 0;
    int                  compares = 0;

    always #25 clk_sys = ~clk_sys;

    pcr_host i_pcr_host (.clk_sys(clk_sys), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
        .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat_w), .wb_ack_i(ack));
    pcr_regs i_pcr_regs (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .pres_shadow(shadow), .pres_comp_active(act),
        .baseline_ref(bref), .irq(irq));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task test_done;
        $display("Counts: %0d compares, %0d fails", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // Read data is taken at the edge that samples ack high.
    always @(posedge clk_sys) begin
        if (ack === 1'b1 && we === 1'b0) begin
            check(dat_r, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hXXXXXXXX);
        end
    end

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
        i_pcr_host.acc(w, a, d, m, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: no acknowledge", $time);
            test_done();
        end
    endtask : bus

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'($urandom), d}, 4'hF);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask : rd

    task pair(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 8'h04, v[7:0]);
    endtask : pair

    task settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    // ======================================================================
    // Main sequence.
    initial begin
        t_in = '{16'h0100, 16'h02EE, 16'h047F, 16'h047E, 16'h8000, 16'h015D, 16'h05DD, 16'h015E,
                 16'h0, 16'h0, 16'h0, 16'h0};
        t_ex = '{16'h02EE, 16'h02EE, 16'h047E, 16'h047E, 16'h015E, 16'h015E, 16'h05DC, 16'h015E,
                 16'h0, 16'h0, 16'h0, 16'h0};
        t_rf = '{0, 0, 0, 0, 1, 1, 1, 1, 0, 1, 0, 1};
        t_er = '{1, 0, 1, 0, 1, 1, 1, 0, 0, 0, 0, 0};
        void'($urandom(23712));
        for (int i = 8; i < 12; i++) begin
            t_in[i] = t_rf[i] ? 16'(350 + $urandom_range(1150)) : 16'(750 + $urandom_range(400));
            t_ex[i] = t_in[i];
        end
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check(shadow, 16'h03F7);
        check(act, 1'b0);
        check(bref, 16'h0190);
        rd(A_PH, `PCR_RST_PRES_H);
        rd(A_PH + 8'h04, `PCR_RST_PRES_L);
        rd(A_BH, `PCR_RST_BASE_H);
        rd(A_BH + 8'h04, `PCR_RST_BASE_L);
        rd(A_SC, `PCR_RST_SCRATCH);
        wr(8'h80, 8'h5A);
        rd(8'h80, 8'h00);
        $display("test reset done");
        wr(A_PH, 8'h04);
        check(shadow, 16'h03F7);
        rd(A_PH, 8'h04);
        wr(A_PH + 8'h04, 8'h00);
        check(shadow, 16'h0400);
        check(act, 1'b1);
        rd(A_ST, 8'h00);
        $display("test shadow done");
        for (int i = 0; i < 12; i++) begin
            s = t_rf[i] ? A_BH : A_PH;
            pair(s, t_in[i]);
            rd(s, t_ex[i][15:8]);
            rd(s + 8'h04, t_ex[i][7:0]);
            check(t_rf[i] ? bref : shadow, t_ex[i]);
            rd(A_ST, {7'h0, t_er[i]});
            wr(A_ST, 8'h01);
        end
        $display("test clamp done");
        wr(A_MK, 8'h01);
        rd(A_MK, 8'h01);
        settle();
        check(irq, 1'b0);
        pair(A_PH, 16'h0000);
        settle();
        check(irq, 1'b1);
        wr(A_ST, 8'h00);
        settle();
        check(irq, 1'b1);
        wr(A_ST, 8'h01);
        settle();
        check(irq, 1'b0);
        wr(A_MK, 8'h00);
        pair(A_PH, 16'hFFFF);
        settle();
        check(irq, 1'b0);
        rd(A_ST, 8'h01);
        $display("test irq done");
        s = 8'($urandom);
        wr(A_SC, s);
        bus(1'b1, A_SC, {24'h0, ~s}, 4'hE);
        rd(A_SC, s);
        check(shadow, 16'h047E);
        check(bref, t_ex[11]);
        // The read checker pops at the same edge, so let it run first.
        settle();
        check(32'(exp_q.size()), 32'h0);
        $display("test scratch done");
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check(shadow, 16'h03F7);
        check(act, 1'b0);
        check(bref, 16'h0190);
        check(irq, 1'b0);
        rd(A_SC, `PCR_RST_SCRATCH);
        rd(A_ST, 8'h00);
        rd(A_PH, `PCR_RST_PRES_H);
        $display("test reset again done");
        test_done();
    end
endmodule : pcr_regs_bench
